/* File: rtl/pacc_accum.sv */
// Eight-bit pulse accumulator with APB register access
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps

// Function
// - Gated mode advances the count once every 64 bus cycles while pin active.
// - Gated count idle before pin activates, stops at trailing edge, keeps overflow.
// - Trailing edge sets edge flag and, when enabled, requests an interrupt.
// - Overflow request outranks the edge request when both are pending.
// - Overflow flag sets on the same edge the count wraps from max to zero.
// - Software can always read the pin level.
// - Edge select picks rising or falling edges for events and interrupt.
// - Edge request gated locally by enable and globally by processor mask.
// - Software reads the edge flag and may clear it.
// - Pin is synchronised, capping event rate at half the bus clock.
// - Edge seen within a cycle sets the flag at that cycle's end.
// - Event mode increments the count on the edge that sets the flag.
// - After a detected edge no new edge is recognised for one cycle.
// - Gated counting uses a free-running divide-by-64 tick independent of pin.
// - Tick tap position follows the timer prescale select setting.
// - Software count accesses never collide with counting updates.
// - Software can preload the count; counting continues from that value.
// - Pin works as edge interrupt source even with accumulation disabled.
// - In gated mode edge select picks the inhibiting level.
// - Overflow and trailing-edge requests are separately maskable.
module pacc_accum (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic shared_port_pin,
	input wire logic global_int_mask,
	output logic ovf_int_req,
	output logic edge_int_req,
	output logic int_req,
	output logic [1:0] int_source
);
	import pacc_pkg::*;

	// Increment helper shared by counting and preload paths
	function automatic logic [7:0] pacc_inc(input logic [7:0] v,
		input logic en);
		pacc_inc = en ? v + 8'h01 : v;
	endfunction

	pacc_ctrl_s ctrl_reg;
	logic [7:0] pulse_count_register;
	logic input_edge_flag;
	logic count_overflow_flag;
	logic pin_meta_reg;
	logic accumulator_input_pin;
	logic pin_prev_reg;
	logic lockout_reg;
	logic [PACC_CHAIN_W-1:0] chain_reg;
	logic [31:0] rdata_reg;

	// APB decode
	wire setup_ph = psel && !penable;
	wire access_ph = psel && penable;
	wire hit_ctrl = (paddr == PACC_OFS_CTRL);
	wire hit_count = (paddr == PACC_OFS_COUNT);
	wire hit_flags = (paddr == PACC_OFS_FLAGS);
	wire hit_pin = (paddr == PACC_OFS_PIN);
	wire addr_ok = hit_ctrl || hit_count || hit_flags || hit_pin;
	wire wr_ctrl = access_ph && pwrite && hit_ctrl;
	wire wr_count = access_ph && pwrite && hit_count;
	wire wr_flags = access_ph && pwrite && hit_flags;

	// Zero wait states; unmapped offsets answer with an error
	assign pready = 1'b1;
	assign pslverr = access_ph && !addr_ok;
	assign prdata = rdata_reg;

	// Edge detection on the synchronised pin
	wire rise = accumulator_input_pin && !pin_prev_reg;
	wire fall = !accumulator_input_pin && pin_prev_reg;
	wire edge_det = !lockout_reg &&
		(ctrl_reg.edge_sel ? rise : fall);

	// Active level is the opposite of the one the selected edge ends on
	wire pin_active = ctrl_reg.edge_sel ? !accumulator_input_pin
		: accumulator_input_pin;

	// Free-running tick; the tap phase moves with the prescale select
	// Widen before shifting; a two-bit shift would lose the select
	wire [PACC_CHAIN_W-1:0] tap_phase =
		PACC_CHAIN_W'(ctrl_reg.prescale) << PACC_TAP_SHIFT;
	wire tick = (chain_reg == tap_phase);

	// Count advance: events in event mode, ticks gated by active level
	wire event_inc = ctrl_reg.enable && !ctrl_reg.gated && edge_det;
	wire gated_inc = ctrl_reg.enable && ctrl_reg.gated &&
		tick && pin_active;
	wire count_inc = event_inc || gated_inc;

	// A write and an increment on one edge merge instead of colliding
	wire [7:0] count_base = wr_count ? pwdata[7:0]
		: pulse_count_register;
	wire [7:0] count_next = pacc_inc(count_base, count_inc);
	wire wrap = count_inc && (count_base == PACC_COUNT_MAX);

	// Flag clears are write-one; a set in the same cycle wins
	wire edge_clr = wr_flags && pwdata[PACC_FLAG_EDGE];
	wire ovf_clr = wr_flags && pwdata[PACC_FLAG_OVF];
	wire edge_flag_next = edge_det || (input_edge_flag && !edge_clr);
	wire ovf_flag_next = wrap || (count_overflow_flag && !ovf_clr);

	// Read mux, snapshot taken in the setup cycle
	wire [31:0] rd_mux =
		hit_ctrl ? {25'h000_0000, ctrl_reg} :
		hit_count ? {24'h00_0000, pulse_count_register} :
		hit_flags ? {30'h000_0000, count_overflow_flag,
			input_edge_flag} :
		hit_pin ? {31'h000_0000, accumulator_input_pin} :
		32'h0000_0000;

	// Two-flop pin synchroniser; only stage two is looked at
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta_reg <= 1'b0;
			accumulator_input_pin <= 1'b0;
			pin_prev_reg <= 1'b0;
		end else begin
			pin_meta_reg <= shared_port_pin;
			accumulator_input_pin <= pin_meta_reg;
			pin_prev_reg <= accumulator_input_pin;
		end
	end

	// One blind cycle after a detection keeps edges two cycles apart
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lockout_reg <= 1'b0;
		end else begin
			lockout_reg <= edge_det;
		end
	end

	// Divider chain runs regardless of pin or enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chain_reg <= '0;
		end else begin
			chain_reg <= chain_reg + 1'b1;
		end
	end

	// Control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= pacc_ctrl_s'(PACC_CTRL_RST);
		end else if (wr_ctrl) begin
			ctrl_reg <= pacc_ctrl_s'(pwdata[PACC_CTRL_W-1:0]);
		end
	end

	// Counter and flags; flag set on the same edge as the count change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_count_register <= PACC_COUNT_RST;
			input_edge_flag <= 1'b0;
			count_overflow_flag <= 1'b0;
		end else begin
			pulse_count_register <= count_next;
			input_edge_flag <= edge_flag_next;
			count_overflow_flag <= ovf_flag_next;
		end
	end

	// Read data captured before the access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_reg <= 32'h0000_0000;
		end else if (setup_ph && !pwrite) begin
			rdata_reg <= rd_mux;
		end
	end

	// Interrupt requests: local enables, global mask, overflow first
	assign ovf_int_req = count_overflow_flag && ctrl_reg.ovf_ie &&
		!global_int_mask;
	assign edge_int_req = input_edge_flag && ctrl_reg.edge_ie &&
		!global_int_mask;
	assign int_req = ovf_int_req || edge_int_req;
	assign int_source = ovf_int_req ? PACC_SRC_OVF :
		edge_int_req ? PACC_SRC_EDGE : PACC_SRC_NONE;

	// Checks next to the logic they guard
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_edge_seen;
		edge_det && !wr_count;
	endsequence

	sequence s_wrap_edge;
		count_inc && !wr_count && pulse_count_register == 8'hFF;
	endsequence

	a_edge_sets_flag: assert property (s_edge_seen |=> input_edge_flag)
		else $error("edge did not set edge flag");

	a_event_count_step: assert property (
		s_edge_seen ##0 (ctrl_reg.enable && !ctrl_reg.gated && !wr_ctrl)
		|=> pulse_count_register == $past(pulse_count_register) + 8'h01)
		else $error("event mode count did not step");

	a_edge_lockout: assert property (edge_det |=> !edge_det)
		else $error("edge recognised within lockout");

	a_wrap_sets_ovf: assert property (s_wrap_edge
		|=> count_overflow_flag && pulse_count_register == 8'h00)
		else $error("wrap did not set overflow flag");

	a_gated_idle: assert property (
		(ctrl_reg.gated && !pin_active && !wr_count && !wr_ctrl)
		|=> $stable(pulse_count_register))
		else $error("gated count moved while inhibited");

	a_gated_tick_only: assert property (
		(ctrl_reg.gated && ctrl_reg.enable && !tick && !wr_count &&
		!wr_ctrl) |=> $stable(pulse_count_register))
		else $error("gated count moved off tick");

	a_tick_period: assert property (tick |-> ##64 tick)
		else $error("tick period not 64 cycles");

	a_hold_disabled: assert property (
		(!ctrl_reg.enable && !wr_count && !wr_ctrl)
		|=> $stable(pulse_count_register))
		else $error("disabled count moved");

	a_ovf_priority: assert property (
		(ovf_int_req && edge_int_req) |-> int_source == PACC_SRC_OVF)
		else $error("edge request outranked overflow");

	a_global_mask: assert property (global_int_mask |-> !int_req)
		else $error("request passed global mask");

	a_flag_clear: assert property (
		(edge_clr && !edge_det) |=> !input_edge_flag)
		else $error("edge flag not cleared");

	a_preload: assert property (
		(wr_count && !count_inc) |=> pulse_count_register == $past(pwdata[7:0]))
		else $error("preload not taken");

	a_pin_read: assert property (
		(setup_ph && !pwrite && hit_pin)
		|=> prdata[0] == $past(accumulator_input_pin))
		else $error("pin level not readable");

	// Further checks on the counting path, the flags, the requests, the pin synchroniser and control writes.
	// They are kept next to the module end so the logic above stays
	// readable; each one names the behaviour it guards in its label.

	// One gated step: enabled, gated, tick and active level together
	sequence s_gated_tick;
		ctrl_reg.enable && ctrl_reg.gated && tick && pin_active &&
			!wr_count;
	endsequence

	// A count write that lands on the same edge as an increment
	sequence s_merged_write;
		wr_count && count_inc;
	endsequence

	a_gated_step: assert property (
		s_gated_tick |=> pulse_count_register ==
			$past(pulse_count_register) + 8'h01)
		else $error("gated count did not step on tick");

	a_merged_write: assert property (
		s_merged_write |=> pulse_count_register ==
			$past(pwdata[7:0]) + 8'h01)
		else $error("write and increment collided");

	// Event mode moves the count only on a detected edge
	a_event_only_edge: assert property (
		(ctrl_reg.enable && !ctrl_reg.gated && !edge_det &&
		!wr_count && !wr_ctrl) |=> $stable(pulse_count_register))
		else $error("event count moved without edge");

	// Flags are sticky until software clears them
	a_edge_sticky: assert property (
		(input_edge_flag && !edge_clr) |=> input_edge_flag)
		else $error("edge flag dropped without clear");

	a_ovf_sticky: assert property (
		(count_overflow_flag && !ovf_clr) |=> count_overflow_flag)
		else $error("overflow flag dropped without clear");

	// Flags never rise without their cause
	a_ovf_cause: assert property (
		(!count_overflow_flag && !wrap) |=> !count_overflow_flag)
		else $error("overflow flag set without wrap");

	a_edge_cause: assert property (
		(!input_edge_flag && !edge_det) |=> !input_edge_flag)
		else $error("edge flag set without edge");

	// Local enables gate each request on its own
	a_ovf_local_gate: assert property (
		!ctrl_reg.ovf_ie |-> !ovf_int_req)
		else $error("overflow request passed local enable");

	a_edge_local_gate: assert property (
		!ctrl_reg.edge_ie |-> !edge_int_req)
		else $error("edge request passed local enable");

	// Nothing pending means no source is named
	a_source_idle: assert property (
		!int_req |-> int_source == PACC_SRC_NONE)
		else $error("source named with no request");

	// Synchroniser delay is exactly two bus cycles once out of reset
	a_sync_delay: assert property (
		$past(presetn, 2) |->
		accumulator_input_pin == $past(shared_port_pin, 2))
		else $error("pin synchroniser delay wrong");

	// Control writes land whole on the access edge
	a_ctrl_write: assert property (
		wr_ctrl |=> ctrl_reg == $past(pwdata[PACC_CTRL_W-1:0]))
		else $error("control write not taken");

	// Edge flag works whether or not the accumulator is enabled
	a_edge_any_mode: assert property (
		(edge_det && !ctrl_reg.enable) |=> input_edge_flag)
		else $error("edge flag lost while disabled");

	// Edge and overflow requests follow their flags in every mode
	a_edge_req_follow: assert property (
		(input_edge_flag && ctrl_reg.edge_ie && !global_int_mask)
		|-> edge_int_req)
		else $error("edge request missing");

	a_ovf_req_follow: assert property (
		(count_overflow_flag && ctrl_reg.ovf_ie && !global_int_mask)
		|-> ovf_int_req)
		else $error("overflow request missing");

	// A wrap in a cycle without a count write returns the count to zero
	a_wrap_to_zero: assert property (
		(wrap && !wr_count) |=> pulse_count_register == 8'h00)
		else $error("wrap did not return to zero");

	// Tick lands where the prescale select puts it
	a_tick_tap: assert property (
		tick |-> chain_reg == tap_phase)
		else $error("tick off its tap");

endmodule

/* File: rtl/pacc_pkg.sv */
// Package for the eight-bit pulse accumulator: map, fields, resets, timing
package pacc_pkg;

	// Register byte offsets on the APB
	localparam logic [7:0] PACC_OFS_CTRL = 8'h00;
	localparam logic [7:0] PACC_OFS_COUNT = 8'h04;
	localparam logic [7:0] PACC_OFS_FLAGS = 8'h08;
	localparam logic [7:0] PACC_OFS_PIN = 8'h0C;

	// Control register field positions
	localparam int PACC_CTRL_ENABLE = 0;
	localparam int PACC_CTRL_GATED = 1;
	localparam int PACC_CTRL_EDGE_SEL = 2;
	localparam int PACC_CTRL_EDGE_IE = 3;
	localparam int PACC_CTRL_OVF_IE = 4;
	localparam int PACC_CTRL_PRESCALE = 5;
	localparam int PACC_CTRL_W = 7;

	// Flags register field positions
	localparam int PACC_FLAG_EDGE = 0;
	localparam int PACC_FLAG_OVF = 1;

	// Reset values
	localparam logic [PACC_CTRL_W-1:0] PACC_CTRL_RST = 7'h00;
	localparam logic [7:0] PACC_COUNT_RST = 8'h00;
	localparam logic [7:0] PACC_COUNT_MAX = 8'hFF;

	// Gated time base: one tick every 64 bus cycles
	localparam int PACC_TICK_DIV = 64;
	localparam int PACC_CHAIN_W = $clog2(PACC_TICK_DIV);
	localparam int PACC_TAP_SHIFT = PACC_CHAIN_W - 2;

	// Interrupt source select, overflow ranks first
	localparam logic [1:0] PACC_SRC_NONE = 2'h0;
	localparam logic [1:0] PACC_SRC_OVF = 2'h1;
	localparam logic [1:0] PACC_SRC_EDGE = 2'h2;

	// Control register as carried through the block
	typedef struct packed {
		logic [1:0] prescale;
		logic ovf_ie;
		logic edge_ie;
		logic edge_sel;
		logic gated;
		logic enable;
	} pacc_ctrl_s;

endpackage

/* File: verif/pacc_pin_src.sv */
// External signal source that drives the shared port pin
`timescale 1ns/100ps
module pacc_pin_src (
	input wire logic pclk,
	output logic shared_port_pin
);
	// Idle low until a pulse is asked for
	initial shared_port_pin = 1'b0;

	// Active pulse, whole cycles; callers keep widths of two or more
	task automatic pulse(input int hi, input int lo);
		shared_port_pin <= 1'b1;
		repeat (hi) @(posedge pclk);
		shared_port_pin <= 1'b0;
		repeat (lo) @(posedge pclk);
	endtask

	// Static level, changed only just after an edge
	task automatic level(input logic v);
		shared_port_pin <= v;
	endtask
endmodule

/* File: verif/pulse_accumulator_8bit_tb.sv */
// Self-checking bench for the eight-bit pulse accumulator
`timescale 1ns/100ps
module pulse_accumulator_8bit_tb;
	import pacc_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic global_int_mask = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, shared_port_pin;
	logic ovf_int_req, edge_int_req, int_req;
	logic [1:0] int_source;
	logic [31:0] rd;
	logic err;
	logic s;
	logic [7:0] start;
	logic [8:0] tot;
	int n;
	int failures = 0;
	int check_count = 0;

	// Bus clock, 50 ns period
	always #25 pclk = ~pclk;

	pacc_accum i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .shared_port_pin(shared_port_pin),
		.global_int_mask(global_int_mask), .ovf_int_req(ovf_int_req),
		.edge_int_req(edge_int_req), .int_req(int_req),
		.int_source(int_source));
	pacc_pin_src i_src (.pclk(pclk), .shared_port_pin(shared_port_pin));

	// Compare and count
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One APB transfer; waits for pready under a bound
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int t;
		t = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1 && t < 16);
		if (t >= 16) begin
			failures++;
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Control word from its fields
	function automatic logic [31:0] ctrl(input logic en, g, es, ei, oi);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[PACC_CTRL_ENABLE] = en;
		v[PACC_CTRL_GATED] = g;
		v[PACC_CTRL_EDGE_SEL] = es;
		v[PACC_CTRL_EDGE_IE] = ei;
		v[PACC_CTRL_OVF_IE] = oi;
		return v;
	endfunction

	// Flags word, edge and overflow
	function automatic logic [31:0] flg(input logic e, input logic o);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[PACC_FLAG_EDGE] = e;
		v[PACC_FLAG_OVF] = o;
		return v;
	endfunction

	// Verdict, the single end of the run
	task automatic end_sim();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Watchdog, well past the expected few thousand cycles
	initial begin
		#(50 * 30000);
		failures++;
		end_sim();
	end

	// Main sequence
	initial begin
		void'($urandom(47));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, PACC_OFS_CTRL, 32'h0000_0000);
		chk("ctrl reset", 32'h0000_0000, rd);
		apb(1'b0, 8'h10, 32'h0000_0000);
		chk("unmapped err", 32'h0000_0001, 32'(err));
		// Event counting: random, wrap and complement preloads, both edges
		for (int i = 0; i < 6; i++) begin
			s = i[0];
			start = (i < 2) ? 8'($urandom) : (i < 4) ? 8'hFD : 8'h9C;
			n = (i < 2) ? $urandom_range(1, 30) : (i < 4) ? 3 : 100;
			apb(1'b1, PACC_OFS_CTRL, ctrl(1'b1, 1'b0, s, 1'b0, 1'b0));
			apb(1'b1, PACC_OFS_FLAGS, flg(1'b1, 1'b1));
			apb(1'b1, PACC_OFS_COUNT, {24'h0000_00, start});
			repeat (n) i_src.pulse($urandom_range(2, 5), $urandom_range(2, 5));
			// Rising edge only; counts just when rising edges are chosen
			i_src.level(1'b1);
			repeat (6) @(posedge pclk);
			tot = {1'b0, start} + 9'(n) + 9'(s);
			apb(1'b0, PACC_OFS_COUNT, 32'h0000_0000);
			chk("event count", {24'h0000_00, tot[7:0]}, rd);
			apb(1'b0, PACC_OFS_FLAGS, 32'h0000_0000);
			chk("event flags", flg(1'b1, tot[8]), rd);
			apb(1'b0, PACC_OFS_PIN, 32'h0000_0000);
			chk("pin high", 32'h0000_0001, rd);
			i_src.level(1'b0);
			repeat (6) @(posedge pclk);
			apb(1'b0, PACC_OFS_PIN, 32'h0000_0000);
			chk("pin low", 32'h0000_0000, rd);
		end
		// Disabled accumulator still raises edge requests
		apb(1'b1, PACC_OFS_CTRL, ctrl(1'b0, 1'b0, 1'b1, 1'b1, 1'b0));
		apb(1'b1, PACC_OFS_FLAGS, flg(1'b1, 1'b1));
		apb(1'b1, PACC_OFS_COUNT, 32'h0000_0055);
		i_src.pulse(3, 6);
		@(negedge pclk);
		chk("edge req", 32'h0000_0001, 32'(edge_int_req));
		@(posedge pclk);
		global_int_mask <= 1'b1;
		@(negedge pclk);
		chk("masked req", 32'h0000_0000, 32'(int_req));
		@(posedge pclk);
		global_int_mask <= 1'b0;
		apb(1'b0, PACC_OFS_COUNT, 32'h0000_0000);
		chk("held count", 32'h0000_0055, rd);
		apb(1'b1, PACC_OFS_FLAGS, flg(1'b1, 1'b0));
		@(negedge pclk);
		chk("cleared req", 32'h0000_0000, 32'(edge_int_req));
		@(posedge pclk);
		// Gated, active high: two ticks from FE wrap to zero
		apb(1'b1, PACC_OFS_CTRL, ctrl(1'b1, 1'b1, 1'b0, 1'b1, 1'b1));
		apb(1'b1, PACC_OFS_COUNT, 32'h0000_00FE);
		i_src.pulse(128, 80);
		apb(1'b0, PACC_OFS_COUNT, 32'h0000_0000);
		chk("gated count", 32'h0000_0000, rd);
		apb(1'b0, PACC_OFS_FLAGS, 32'h0000_0000);
		chk("gated flags", flg(1'b1, 1'b1), rd);
		@(negedge pclk);
		chk("both pending", 32'(PACC_SRC_OVF), 32'(int_source));
		chk("ovf req", 32'h0000_0001, 32'(ovf_int_req));
		@(posedge pclk);
		apb(1'b1, PACC_OFS_FLAGS, flg(1'b0, 1'b1));
		@(negedge pclk);
		chk("edge only", 32'(PACC_SRC_EDGE), 32'(int_source));
		chk("ovf req off", 32'h0000_0000, 32'(ovf_int_req));
		@(posedge pclk);
		// Gated, active low: counts while the pin idles low
		apb(1'b1, PACC_OFS_CTRL, ctrl(1'b1, 1'b1, 1'b1, 1'b0, 1'b0));
		apb(1'b1, PACC_OFS_COUNT, 32'h0000_0000);
		repeat (192) @(posedge pclk);
		apb(1'b0, PACC_OFS_COUNT, 32'h0000_0000);
		chk("low gate", 32'h0000_0001, 32'(rd >= 2 && rd <= 4));
		end_sim();
	end
endmodule
